// ### verilog/ieipc_pkg.sv
// constants and register map of the input edge interrupt and pulse catch block
package ieipc_pkg;

    // sizes
    localparam int NUM_IRQ_IN = 6;
    localparam int NUM_FAST_IN = 8;
    localparam int NUM_ADAPTER_IN = 4;
    localparam int DELAY_W = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int AC_COUNT_W = 5;

    // clock and times
    localparam int CLOCK_HZ = 25_000_000;
    localparam int MS_TICK_US = 1000;
    localparam int MS_TICK_CYCLES = (CLOCK_HZ / 1_000_000) * MS_TICK_US;
    localparam int AC_RESPONSE_MS = 26;
    localparam int MIN_EDGE_HOLD_NS = 5000;
    localparam int MIN_EDGE_HOLD_CYCLES = (MIN_EDGE_HOLD_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;

    // register word offsets
    localparam logic [ADDR_W-1:0] OFF_IRQ_DISABLE = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_CATCH_FLAGS = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_INPUT_LEVEL = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_PENDING_VECTOR = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_DELAY_BASE = 4'h8;

    // field positions
    localparam int CTRL_ADAPTER_SEL_BIT = 0;
    localparam int VECTOR_VALID_BIT = 4;

    // reset values
    localparam logic [NUM_IRQ_IN-1:0] RESET_IRQ_DISABLE = 6'h00;
    localparam logic [2*NUM_IRQ_IN-1:0] RESET_IRQ_MASK = 12'h000;
    localparam logic [DELAY_W-1:0] RESET_DELAY_MS = 8'h00;

endpackage : ieipc_pkg

// ### verilog/ieipc_ms_tick.sv
// one millisecond tick generator for the interrupt delay and the ac input filter
module ieipc_ms_tick import ieipc_pkg::*; #(
    parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // tick out
    output logic tick
);

    localparam logic [15:0] LAST_COUNT = 16'(TICK_CYCLES - 1);

    logic [15:0] count;
    logic [15:0] next_count;
    logic next_tick;

    always_comb begin
        next_count = count + 16'h0001;
        next_tick = 1'b0;
        if (count == LAST_COUNT) begin
            next_count = 16'h0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            count <= 16'h0000;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    chk_tick_spacing: assert property (@(posedge clock) disable iff (reset)
        (tick && TICK_CYCLES > 1) |=> !tick) else $error("ms tick came on two cycles in a row");

endmodule : ieipc_ms_tick

// ### verilog/ieipc_edge_unit.sv
// edge detection and delayed interrupt request for one interrupt input
module ieipc_edge_unit import ieipc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // input and control
    input wire logic level,
    input wire logic enable,
    input wire logic tick,
    input wire logic [DELAY_W-1:0] delayMs,
    // requests
    output logic riseEvent,
    output logic fallEvent
);

    logic prevLevel;
    logic [DELAY_W-1:0] riseCount;
    logic [DELAY_W-1:0] fallCount;
    logic next_prevLevel;
    logic [DELAY_W-1:0] next_riseCount;
    logic [DELAY_W-1:0] next_fallCount;
    logic next_riseEvent;
    logic next_fallEvent;
    logic rise;
    logic fall;

    // one step of a delay countdown: returns {event, new count}
    function automatic logic [DELAY_W:0] delayStep(input logic en, input logic edgeSeen,
                                                   input logic [DELAY_W-1:0] cnt, input logic tk,
                                                   input logic [DELAY_W-1:0] dly);
        logic [DELAY_W:0] r;
        r = {1'b0, cnt};
        if (!en) begin
            r = '0;
        end else if (cnt != '0) begin
            if (tk) begin
                r = {(cnt == 8'h01), cnt - 8'h01};
            end
        end else if (edgeSeen) begin
            r = (dly == '0) ? {1'b1, 8'h00} : {1'b0, dly};
        end
        return r;
    endfunction : delayStep

    always_comb begin
        rise = level & ~prevLevel;
        fall = ~level & prevLevel;
        next_prevLevel = level;
        {next_riseEvent, next_riseCount} = delayStep(enable, rise, riseCount, tick, delayMs);
        {next_fallEvent, next_fallCount} = delayStep(enable, fall, fallCount, tick, delayMs);
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            prevLevel <= 1'b0;
            riseCount <= '0;
            fallCount <= '0;
            riseEvent <= 1'b0;
            fallEvent <= 1'b0;
        end else begin
            prevLevel <= next_prevLevel;
            riseCount <= next_riseCount;
            fallCount <= next_fallCount;
            riseEvent <= next_riseEvent;
            fallEvent <= next_fallEvent;
        end
    end

    sequence seq_rise_now;
        enable && level && !prevLevel && riseCount == '0 && delayMs == '0;
    endsequence
    sequence seq_rise_timed;
        enable && tick && riseCount == 8'h01;
    endsequence

    chk_rise_immediate: assert property (@(posedge clock) disable iff (reset)
        seq_rise_now |=> riseEvent) else $error("rising edge with zero delay gave no request");
    chk_rise_cause: assert property (@(posedge clock) disable iff (reset)
        riseEvent |-> $past(enable) && ($past(riseCount) == 8'h01 || $past(rise)))
        else $error("rising request without an edge or expired delay");
    chk_rise_expiry: assert property (@(posedge clock) disable iff (reset)
        seq_rise_timed |=> riseEvent) else $error("expired rise delay gave no request");
    chk_fall_delayed: assert property (@(posedge clock) disable iff (reset)
        (enable && fall && fallCount == '0 && delayMs != '0) |=> !fallEvent && fallCount == $past(delayMs))
        else $error("falling edge did not start its delay");
    chk_disabled_quiet: assert property (@(posedge clock) disable iff (reset)
        !enable |=> !riseEvent && !fallEvent && riseCount == '0) else $error("disabled input raised a request");

endmodule : ieipc_edge_unit

// ### verilog/ieipc_top.sv
// input edge interrupts, interrupt delay and pulse catch flags with a plain register port
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module ieipc_top import ieipc_pkg::*; #(
    parameter int TICK_CYCLES = MS_TICK_CYCLES,
    parameter bit AC_INPUT = 1'b0
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // field inputs
    input wire logic [NUM_FAST_IN-1:0] fastInput,
    input wire logic [NUM_ADAPTER_IN-1:0] adapterInput,
    // register port
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [DATA_W-1:0] readData,
    // interrupt
    output logic irq
);

    localparam int SYNC_W = NUM_FAST_IN + NUM_ADAPTER_IN;
    localparam int STAT_W = 2 * NUM_IRQ_IN;
    localparam logic [AC_COUNT_W-1:0] AC_LAST = AC_COUNT_W'(AC_RESPONSE_MS);

    // synchronisers
    logic [SYNC_W-1:0] syncFirst;
    logic [SYNC_W-1:0] syncSecond;
    logic [NUM_FAST_IN-1:0] rawLevel;
    logic [NUM_FAST_IN-1:0] level;

    // registers
    logic [NUM_IRQ_IN-1:0] irqDisable;
    logic [STAT_W-1:0] irqStatus;
    logic [STAT_W-1:0] irqMask;
    logic [NUM_FAST_IN-1:0] catchFlags;
    logic [NUM_FAST_IN-1:0] catchPrev;
    logic adapterSel;
    logic [DELAY_W-1:0] delayMs [NUM_IRQ_IN];
    logic [NUM_IRQ_IN-1:0] next_irqDisable;
    logic [STAT_W-1:0] next_irqStatus;
    logic [STAT_W-1:0] next_irqMask;
    logic [NUM_FAST_IN-1:0] next_catchFlags;
    logic [NUM_FAST_IN-1:0] next_catchPrev;
    logic next_adapterSel;
    logic [DELAY_W-1:0] next_delayMs [NUM_IRQ_IN];
    logic [DATA_W-1:0] next_readData;
    logic next_irq;

    // internal events
    logic tick;
    logic featureOn;
    logic [NUM_IRQ_IN-1:0] riseEv;
    logic [NUM_IRQ_IN-1:0] fallEv;
    logic [STAT_W-1:0] edgeEv;
    logic [NUM_FAST_IN-1:0] catchEv;
    logic [STAT_W-1:0] pendingBits;
    logic [4:0] pendingVector;

    // lowest pending request: {valid, vector}; even vector is falling, odd is rising
    function automatic logic [4:0] firstPending(input logic [STAT_W-1:0] bits);
        logic [4:0] r;
        r = 5'h00;
        for (int k = STAT_W - 1; k >= 0; k--) begin
            if (bits[k]) begin
                r = {1'b1, 4'(k)};
            end
        end
        return r;
    endfunction : firstPending

    // word write strobe for one offset
    function automatic logic writeHit(input logic ws, input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] off);
        return ws && (a == off);
    endfunction : writeHit

    // two flip-flop synchronisers, sampled fast enough for the counter input rates
    always_ff @(posedge clock) begin
        if (reset) begin
            syncFirst <= '0;
            syncSecond <= '0;
        end else begin
            syncFirst <= {adapterInput, fastInput};
            syncSecond <= syncFirst;
        end
    end

    // adapter terminals stand in for main inputs 0 to 3 when selected
    always_comb begin
        rawLevel = syncSecond[NUM_FAST_IN-1:0];
        if (adapterSel) begin
            rawLevel[NUM_ADAPTER_IN-1:0] = syncSecond[SYNC_W-1:NUM_FAST_IN];
        end
    end

    assign featureOn = !AC_INPUT;

    ieipc_ms_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock(clock),
        .reset(reset),
        .tick(tick)
    );

    // ac variant: a change shows only after it has stood for the response time
    generate
        if (AC_INPUT) begin : g_ac
            logic [AC_COUNT_W-1:0] acCount [NUM_FAST_IN];
            logic [AC_COUNT_W-1:0] next_acCount [NUM_FAST_IN];
            logic [NUM_FAST_IN-1:0] acLevel;
            logic [NUM_FAST_IN-1:0] next_acLevel;
            always_comb begin
                next_acLevel = acLevel;
                for (int k = 0; k < NUM_FAST_IN; k++) begin
                    next_acCount[k] = acCount[k];
                    if (rawLevel[k] == acLevel[k]) begin
                        next_acCount[k] = '0;
                    end else if (acCount[k] == AC_LAST) begin
                        next_acLevel[k] = rawLevel[k];
                        next_acCount[k] = '0;
                    end else if (tick) begin
                        next_acCount[k] = acCount[k] + 5'h01;
                    end
                end
            end
            always_ff @(posedge clock) begin
                if (reset) begin
                    acLevel <= '0;
                    for (int k = 0; k < NUM_FAST_IN; k++) begin
                        acCount[k] <= '0;
                    end
                end else begin
                    acLevel <= next_acLevel;
                    acCount <= next_acCount;
                end
            end
            assign level = acLevel;
            for (genvar j = 0; j < NUM_FAST_IN; j++) begin : g_ac_chk
                chk_ac_wait: assert property (@(posedge clock) disable iff (reset)
                    acLevel[j] != $past(acLevel[j]) |-> $past(acCount[j]) == AC_LAST)
                    else $error("ac input changed before its response time");
            end
        end else begin : g_dc
            assign level = rawLevel;
        end
    endgenerate

    // one edge unit per interrupt input
    generate
        for (genvar i = 0; i < NUM_IRQ_IN; i++) begin : g_edge
            ieipc_edge_unit u_edge (
                .clock(clock),
                .reset(reset),
                .level(level[i]),
                .enable(featureOn && !irqDisable[i]),
                .tick(tick),
                .delayMs(delayMs[i]),
                .riseEvent(riseEv[i]),
                .fallEvent(fallEv[i])
            );
            assign edgeEv[2*i] = fallEv[i];
            assign edgeEv[2*i+1] = riseEv[i];
        end
    endgenerate

    // register file, sticky status and catch flags
    always_comb begin
        catchEv = level & ~catchPrev & {NUM_FAST_IN{featureOn}};
        next_catchPrev = level;
        next_irqDisable = irqDisable;
        next_irqMask = irqMask;
        next_adapterSel = adapterSel;
        next_delayMs = delayMs;
        next_irqStatus = irqStatus;
        next_catchFlags = catchFlags;
        if (writeHit(writeStrobe, address, OFF_IRQ_DISABLE)) begin
            next_irqDisable = writeData[NUM_IRQ_IN-1:0];
        end
        if (writeHit(writeStrobe, address, OFF_IRQ_MASK)) begin
            next_irqMask = writeData[STAT_W-1:0];
        end
        if (writeHit(writeStrobe, address, OFF_CONTROL)) begin
            next_adapterSel = writeData[CTRL_ADAPTER_SEL_BIT];
        end
        for (int k = 0; k < NUM_IRQ_IN; k++) begin
            if (writeHit(writeStrobe, address, OFF_DELAY_BASE + 4'(k))) begin
                next_delayMs[k] = writeData[DELAY_W-1:0];
            end
        end
        if (writeHit(writeStrobe, address, OFF_IRQ_STATUS)) begin
            next_irqStatus = irqStatus & ~writeData[STAT_W-1:0];
        end
        if (writeHit(writeStrobe, address, OFF_CATCH_FLAGS)) begin
            next_catchFlags = catchFlags & ~writeData[NUM_FAST_IN-1:0];
        end
        // a new event wins over a clear in the same cycle
        next_irqStatus = next_irqStatus | edgeEv;
        next_catchFlags = next_catchFlags | catchEv;
        next_irq = |(irqStatus & irqMask);
    end

    // read answer, one cycle after the strobe and zero otherwise
    always_comb begin
        pendingBits = irqStatus & irqMask;
        pendingVector = firstPending(pendingBits);
        next_readData = '0;
        if (readStrobe) begin
            if (address == OFF_IRQ_DISABLE) begin
                next_readData = DATA_W'(irqDisable);
            end else if (address == OFF_IRQ_STATUS) begin
                next_readData = DATA_W'(irqStatus);
            end else if (address == OFF_IRQ_MASK) begin
                next_readData = DATA_W'(irqMask);
            end else if (address == OFF_CATCH_FLAGS) begin
                next_readData = DATA_W'(catchFlags);
            end else if (address == OFF_INPUT_LEVEL) begin
                next_readData = DATA_W'(level);
            end else if (address == OFF_CONTROL) begin
                next_readData = DATA_W'(adapterSel);
            end else if (address == OFF_PENDING_VECTOR) begin
                next_readData = DATA_W'(pendingVector);
            end else begin
                for (int k = 0; k < NUM_IRQ_IN; k++) begin
                    if (address == OFF_DELAY_BASE + 4'(k)) begin
                        next_readData = DATA_W'(delayMs[k]);
                    end
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            irqDisable <= RESET_IRQ_DISABLE;
            irqMask <= RESET_IRQ_MASK;
            irqStatus <= '0;
            catchFlags <= '0;
            catchPrev <= '0;
            adapterSel <= 1'b0;
            for (int k = 0; k < NUM_IRQ_IN; k++) begin
                delayMs[k] <= RESET_DELAY_MS;
            end
            readData <= '0;
            irq <= 1'b0;
        end else begin
            irqDisable <= next_irqDisable;
            irqMask <= next_irqMask;
            irqStatus <= next_irqStatus;
            catchFlags <= next_catchFlags;
            catchPrev <= next_catchPrev;
            adapterSel <= next_adapterSel;
            delayMs <= next_delayMs;
            readData <= next_readData;
            irq <= next_irq;
        end
    end

    sequence seq_status_keep;
        !(writeStrobe && address == OFF_IRQ_STATUS);
    endsequence
    sequence seq_catch_keep;
        !(writeStrobe && address == OFF_CATCH_FLAGS);
    endsequence

    chk_status_sticky: assert property (@(posedge clock) disable iff (reset)
        seq_status_keep |=> (irqStatus & $past(irqStatus)) == $past(irqStatus))
        else $error("interrupt status bit dropped without a clear");
    chk_status_set_wins: assert property (@(posedge clock) disable iff (reset)
        (|edgeEv) |=> (irqStatus & $past(edgeEv)) == $past(edgeEv))
        else $error("edge request lost in its status bit");
    chk_catch_latch: assert property (@(posedge clock) disable iff (reset)
        (|catchEv) |=> (catchFlags & $past(catchEv)) == $past(catchEv))
        else $error("catch flag missed a turn on");
    chk_catch_hold: assert property (@(posedge clock) disable iff (reset)
        seq_catch_keep |=> (catchFlags & $past(catchFlags)) == $past(catchFlags))
        else $error("catch flag fell without a clear");
    chk_disable_blocks: assert property (@(posedge clock) disable iff (reset)
        $past(irqDisable[0]) && irqDisable[0] |-> !riseEv[0] && !fallEv[0])
        else $error("disabled input 0 raised a request");
    chk_ac_no_events: assert property (@(posedge clock) disable iff (reset)
        AC_INPUT |-> edgeEv == '0 && catchEv == '0) else $error("ac variant produced a fast event");
    chk_irq_level: assert property (@(posedge clock) disable iff (reset)
        ##1 irq == $past(|(irqStatus & irqMask))) else $error("interrupt output does not follow masked status");
    chk_read_window: assert property (@(posedge clock) disable iff (reset)
        !readStrobe |=> readData == '0) else $error("read data outside the answer cycle");
    chk_dc_follows: assert property (@(posedge clock) disable iff (reset)
        !AC_INPUT && !adapterSel |-> level == syncSecond[NUM_FAST_IN-1:0])
        else $error("input level not taken from the synchroniser");

    // register read answers
    sequence seq_read_disable;
        readStrobe && address == OFF_IRQ_DISABLE;
    endsequence
    sequence seq_read_status;
        readStrobe && address == OFF_IRQ_STATUS;
    endsequence
    sequence seq_read_mask;
        readStrobe && address == OFF_IRQ_MASK;
    endsequence
    sequence seq_read_catch;
        readStrobe && address == OFF_CATCH_FLAGS;
    endsequence
    sequence seq_read_delay;
        readStrobe && address == OFF_DELAY_BASE;
    endsequence

    chk_read_disable: assert property (@(posedge clock) disable iff (reset)
        seq_read_disable |=> readData == DATA_W'($past(irqDisable)))
        else $error("disable word read back wrong");
    chk_read_status: assert property (@(posedge clock) disable iff (reset)
        seq_read_status |=> readData == DATA_W'($past(irqStatus)))
        else $error("status word read back wrong");
    chk_read_mask: assert property (@(posedge clock) disable iff (reset)
        seq_read_mask |=> readData == DATA_W'($past(irqMask)))
        else $error("mask word read back wrong");
    chk_read_catch: assert property (@(posedge clock) disable iff (reset)
        seq_read_catch |=> readData == DATA_W'($past(catchFlags)))
        else $error("catch word read back wrong");
    chk_read_delay: assert property (@(posedge clock) disable iff (reset)
        seq_read_delay |=> readData == DATA_W'($past(delayMs[0])))
        else $error("delay word read back wrong");

    // input routing, feature gating and pending vector valid bit
    chk_catch_ac_off: assert property (@(posedge clock) disable iff (reset)
        AC_INPUT |-> catchFlags == '0) else $error("ac variant set a catch flag");
    chk_adapter_route: assert property (@(posedge clock) disable iff (reset)
        !AC_INPUT && adapterSel |-> level[NUM_ADAPTER_IN-1:0] == syncSecond[SYNC_W-1:NUM_FAST_IN])
        else $error("adapter level not routed to inputs 0 to 3");
    chk_sync_chain: assert property (@(posedge clock) disable iff (reset)
        ##1 syncSecond == $past(syncFirst)) else $error("synchroniser stage skipped");
    chk_pending_valid: assert property (@(posedge clock) disable iff (reset)
        pendingVector[4] == |pendingBits) else $error("pending vector valid bit wrong");

endmodule : ieipc_top

// ### dv/ieipc_sensor_model.sv
// sensor model that moves the fast field inputs no faster than the minimum hold times; adapter inputs follow at once
module ieipc_sensor_model import ieipc_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // levels wanted by the bench
    input wire logic [NUM_FAST_IN-1:0] wantFast,
    input wire logic [NUM_ADAPTER_IN-1:0] wantAdapter,
    // field side
    output logic [NUM_FAST_IN-1:0] fastInput,
    output logic [NUM_ADAPTER_IN-1:0] adapterInput
);
    timeunit 1ns;
    timeprecision 1ns;
    int holdCount [NUM_FAST_IN];
    // inputs 6 and 7 stay on ten times longer
    function automatic int minHold(input int i, input logic level);
        return (i >= 6 && level) ? 10 * MIN_EDGE_HOLD_CYCLES : MIN_EDGE_HOLD_CYCLES;
    endfunction : minHold
    always @(posedge clock) begin
        adapterInput <= reset ? 4'h0 : wantAdapter;
        for (int i = 0; i < NUM_FAST_IN; i++) begin
            if (reset) begin
                fastInput[i] <= 1'b0;
                holdCount[i] <= 0;
            end else if (wantFast[i] != fastInput[i] && holdCount[i] >= minHold(i, fastInput[i])) begin
                fastInput[i] <= wantFast[i];
                holdCount[i] <= 0;
            end else begin
                holdCount[i] <= holdCount[i] + 1;
            end
        end
    end
endmodule : ieipc_sensor_model

// ### dv/test_ieipc_top.sv
// self-checking bench of the edge interrupt and pulse catch block
module test_ieipc_top import ieipc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICK = 10;
    localparam int SETTLE = 140;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [NUM_FAST_IN-1:0] wantFast = 8'h00;
    logic [NUM_ADAPTER_IN-1:0] wantAdapter = 4'h0;
    logic [NUM_FAST_IN-1:0] fastInput;
    logic [NUM_ADAPTER_IN-1:0] adapterInput;
    logic [ADDR_W-1:0] address = 4'h0;
    logic [DATA_W-1:0] writeData = 32'h0;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic [DATA_W-1:0] readData, acReadData, rd, acRd, p;
    logic irq, acIrq;
    int badCount = 0;
    int checksDone = 0;
    int cycles = 0;
    int seed = 39;
    int n;
    always #20 clock = ~clock;
    ieipc_sensor_model ieipc_sensor_model_inst (.clock(clock), .reset(reset), .wantFast(wantFast),
        .wantAdapter(wantAdapter), .fastInput(fastInput), .adapterInput(adapterInput));
    ieipc_top #(.TICK_CYCLES(TICK), .AC_INPUT(1'b0)) ieipc_top_inst (.clock(clock), .reset(reset),
        .fastInput(fastInput), .adapterInput(adapterInput), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .irq(irq));
    ieipc_top #(.TICK_CYCLES(TICK), .AC_INPUT(1'b1)) ieipc_top_ac_inst (.clock(clock), .reset(reset),
        .fastInput(fastInput), .adapterInput(adapterInput), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(acReadData), .irq(acIrq));
    task automatic tallyAndFinish;
        $display("comparisons %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tallyAndFinish
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] expected);
        checksDone++;
        if (seen !== expected) begin
            badCount++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, expected);
        end
    endtask : check
    task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        writeStrobe <= 1'b1;
        address <= a;
        writeData <= d;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask : regWrite
    task automatic regRead(input logic [ADDR_W-1:0] a);
        @(posedge clock);
        readStrobe <= 1'b1;
        address <= a;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1;
        rd = readData;
        acRd = acReadData;
    endtask : regRead
    // writable width of each word, zero for flags, read-only and unmapped words
    function automatic logic [DATA_W-1:0] rwMask(input int a);
        case (a)
            0: return 32'h3F;
            2: return 32'hFFF;
            5: return 32'h1;
            8, 9, 10, 11, 12, 13: return 32'hFF;
            default: return 32'h0;
        endcase
    endfunction : rwMask
    function automatic logic [DATA_W-1:0] riseBits(input logic [DATA_W-1:0] lv);
        logic [DATA_W-1:0] r;
        r = 32'h0;
        for (int i = 0; i < NUM_IRQ_IN; i++) begin
            r[2 * i + 1] = lv[i];
        end
        return r;
    endfunction : riseBits
    task automatic edgeCase(input int i, input logic off);
        regWrite(OFF_IRQ_DISABLE, off ? (32'h1 << i) : 32'h0);
        wantFast[i] <= 1'b1;
        repeat (SETTLE) @(posedge clock);
        regRead(OFF_IRQ_STATUS);
        check(rd, off ? 32'h0 : (32'h2 << (2 * i)));
        check({31'h0, irq}, {31'h0, ~off});
        regRead(OFF_PENDING_VECTOR);
        check(rd, off ? 32'h0 : (32'h11 + 2 * i));
        regWrite(OFF_IRQ_STATUS, 32'hFFF);
        wantFast[i] <= 1'b0;
        repeat (SETTLE) @(posedge clock);
        regRead(OFF_IRQ_STATUS);
        check(rd, off ? 32'h0 : (32'h1 << (2 * i)));
        regWrite(OFF_IRQ_STATUS, 32'hFFF);
        regRead(OFF_IRQ_STATUS);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
    endtask : edgeCase
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            badCount++;
            tallyAndFinish();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            regRead(a[ADDR_W-1:0]);
            check(rd, 32'h0);
        end
        for (int a = 0; a < 16; a++) begin
            p = $random(seed);
            regWrite(a[ADDR_W-1:0], p);
            regRead(a[ADDR_W-1:0]);
            check(rd, p & rwMask(a));
            regWrite(a[ADDR_W-1:0], 32'h0);
        end
        $display("test registers done");
        regWrite(OFF_IRQ_MASK, 32'hFFF);
        for (int i = 0; i < 2 * NUM_IRQ_IN; i++) begin
            edgeCase(i % NUM_IRQ_IN, i >= NUM_IRQ_IN);
        end
        regWrite(OFF_IRQ_DISABLE, 32'h0);
        $display("test edges done");
        n = 2 + ($unsigned($random(seed)) % 5);
        regWrite(OFF_DELAY_BASE, n);
        wantFast[0] <= 1'b1;
        repeat ((n - 1) * TICK - 2) @(posedge clock);
        regRead(OFF_IRQ_STATUS);
        check(rd, 32'h0);
        repeat (2 * TICK) @(posedge clock);
        regRead(OFF_IRQ_STATUS);
        check(rd, 32'h2);
        regWrite(OFF_IRQ_MASK, 32'h0);
        regRead(OFF_PENDING_VECTOR);
        check({rd[31:1], irq}, 32'h0);
        regWrite(OFF_IRQ_MASK, 32'hFFF);
        regWrite(OFF_IRQ_STATUS, 32'h2);
        wantFast[0] <= 1'b0;
        repeat (SETTLE + 6 * TICK) @(posedge clock);
        regWrite(OFF_DELAY_BASE, 32'h0);
        regWrite(OFF_IRQ_STATUS, 32'hFFF);
        $display("test delay done");
        p = ($random(seed) & 32'hFF) | 32'h81;
        regWrite(OFF_CATCH_FLAGS, 32'hFF);
        wantFast <= p[7:0];
        repeat (11 * SETTLE) @(posedge clock);
        regRead(OFF_INPUT_LEVEL);
        check(rd, p);
        check(acRd, p);
        regRead(OFF_IRQ_STATUS);
        check(acRd, 32'h0);
        check({31'h0, acIrq}, 32'h0);
        wantFast <= 8'h00;
        repeat (SETTLE) @(posedge clock);
        regRead(OFF_INPUT_LEVEL);
        check(rd, 32'h0);
        check(acRd, p);
        regRead(OFF_CATCH_FLAGS);
        check(rd, p);
        check(acRd, 32'h0);
        regWrite(OFF_CATCH_FLAGS, p);
        regWrite(OFF_IRQ_STATUS, 32'hFFF);
        regRead(OFF_CATCH_FLAGS);
        check(rd, 32'h0);
        $display("test pulse catch done");
        // main inputs 0 to 3 stay idle while the adapter carries them
        p = ($random(seed) & 32'hF) | 32'h1;
        regWrite(OFF_CONTROL, 32'h1);
        wantAdapter <= p[3:0];
        repeat (SETTLE) @(posedge clock);
        regRead(OFF_IRQ_STATUS);
        check(rd, riseBits(p));
        regRead(OFF_INPUT_LEVEL);
        check(rd, p);
        wantAdapter <= 4'h0;
        repeat (SETTLE) @(posedge clock);
        regWrite(OFF_CONTROL, 32'h0);
        $display("test adapter done");
        tallyAndFinish();
    end
endmodule : test_ieipc_top
